// ===== hw/ple_status_bank.sv
// PLL calibration, lock status, sticky event and loss-of-lock counter bank.
// Assumes analog status arrives asynchronously and configuration comes from
// registers on core_clk; registers are reached through the processor port.
`timescale 1ns/100ps
`default_nettype none

module ple_status_bank
  import ple_pkg::*;
#(
  parameter logic [15:0] DB_MID_CYC  = PLE_DB_MID_CYC,
  parameter logic [15:0] DB_LONG_CYC = PLE_DB_LONG_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire ple_analog_t  analog_in,
  input  wire ple_cfg_t     cfg,
  input  wire ple_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  output logic              lock_ind
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ple_analog_t          sync1;
    ple_analog_t          sync2;
    logic                 lock_q;
    logic                 held;
    logic [PLE_EVT_W-1:0] evt;
    logic [PLE_CNT_W-1:0] cnt;
    logic [7:0]           rdata;
  } ple_regs_t;

  ple_regs_t            regs_ff;
  ple_regs_t            nxt_regs;
  logic                 db_lock;
  logic                 ind;
  logic                 lock_fall;
  logic [PLE_EVT_W-1:0] evt_set;
  logic [PLE_EVT_W-1:0] evt_clr;
  logic [PLE_CNT_W-1:0] cnt_base;

  function automatic logic [PLE_CNT_W-1:0] sat_inc(input logic [PLE_CNT_W-1:0] v);
    logic [PLE_CNT_W-1:0] r;
    r = v;
    if (v != PLE_CNT_MAX) begin
      r = v + PLE_CNT_W'(1);
    end
    return r;
  endfunction : sat_inc

  function automatic logic wr_hit(input ple_reg_req_t q, input logic [1:0] idx);
    return q.wr && (q.idx == idx);
  endfunction : wr_hit

  // ==========================================================================
  // Lock qualification
  // ==========================================================================
  // Debouncer sees only the second synchroniser stage
  ple_lock_debounce #(
    .MID_CYC  (DB_MID_CYC),
    .LONG_CYC (DB_LONG_CYC)
  ) u_debounce (
    .core_clk  (core_clk),
    .rst       (rst),
    .raw_lock  (regs_ff.sync2.lock),
    .timer_sel (cfg.lock_timer_sel),
    .lock_out  (db_lock)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_regs       = regs_ff;
    nxt_regs.sync1 = analog_in;
    nxt_regs.sync2 = regs_ff.sync1;

    // Latch clears when one-shot mode is left, so real-time mode resumes
    nxt_regs.held = cfg.one_shot_lock_mode && (regs_ff.held || db_lock);
    if (cfg.lock_det_disable) begin
      ind = 1'b1;
    end else begin
      ind = db_lock || (cfg.one_shot_lock_mode && regs_ff.held);
    end
    nxt_regs.lock_q = ind;

    lock_fall = regs_ff.lock_q && !ind;

    evt_set                  = PLE_EVT_RST;
    evt_set[PLE_RAIL_HI_BIT] = regs_ff.sync2.rail_hi;
    evt_set[PLE_RAIL_LO_BIT] = regs_ff.sync2.rail_lo;
    evt_set[PLE_LOCK_BIT]    = lock_fall;
    evt_clr = PLE_EVT_RST;
    if (wr_hit(reg_req, PLE_IDX_EVENTS)) begin
      evt_clr = reg_req.wdata[PLE_EVT_W-1:0];
    end
    // A new event in the clearing cycle survives the clear
    nxt_regs.evt = (regs_ff.evt & ~evt_clr) | evt_set;

    cnt_base = regs_ff.cnt;
    if (wr_hit(reg_req, PLE_IDX_LOL_CNT)) begin
      cnt_base = reg_req.wdata[PLE_CNT_W-1:0];
    end
    // A loss in the write cycle counts on top of the loaded value
    if (lock_fall) begin
      nxt_regs.cnt = sat_inc(cnt_base);
    end else begin
      nxt_regs.cnt = cnt_base;
    end

    nxt_regs.rdata = PLE_REG_RST;
    case (reg_req.idx)
      PLE_IDX_CAL_STS: begin
        nxt_regs.rdata[PLE_CAL_FAIL_BIT]   = regs_ff.sync2.cal_fail;
        nxt_regs.rdata[PLE_CAL_DONE_BIT]   = regs_ff.sync2.cal_done;
        nxt_regs.rdata[PLE_BAND_W-1:0]     = regs_ff.sync2.band;
      end
      PLE_IDX_LIVE_STS: begin
        nxt_regs.rdata[PLE_RAIL_HI_BIT]    = regs_ff.sync2.rail_hi;
        nxt_regs.rdata[PLE_RAIL_LO_BIT]    = regs_ff.sync2.rail_lo;
        nxt_regs.rdata[PLE_LOCK_BIT]       = regs_ff.lock_q;
      end
      PLE_IDX_EVENTS: begin
        nxt_regs.rdata[PLE_EVT_W-1:0]      = regs_ff.evt;
      end
      PLE_IDX_LOL_CNT: begin
        nxt_regs.rdata[PLE_CNT_W-1:0]      = regs_ff.cnt;
      end
      default: begin
        nxt_regs.rdata = PLE_REG_RST;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regs_ff.sync1  <= '0;
      regs_ff.sync2  <= '0;
      regs_ff.lock_q <= 1'b0;
      regs_ff.held   <= 1'b0;
      regs_ff.evt    <= PLE_EVT_RST;
      regs_ff.cnt    <= PLE_CNT_RST;
      regs_ff.rdata  <= PLE_REG_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign reg_rdata = regs_ff.rdata;
  assign lock_ind  = regs_ff.lock_q;

endmodule : ple_status_bank
`default_nettype wire

// ===== shared/ple_pkg.sv
// Package for the PLL lock, status and event register bank.
// Assumes a single system clock domain and a synchronous, active-high reset.
package ple_pkg;

  // ==========================================================================
  // Register indices on the processor-port register access
  // ==========================================================================
  localparam logic [1:0] PLE_IDX_CAL_STS  = 2'h0;
  localparam logic [1:0] PLE_IDX_LIVE_STS = 2'h1;
  localparam logic [1:0] PLE_IDX_EVENTS   = 2'h2;
  localparam logic [1:0] PLE_IDX_LOL_CNT  = 2'h3;

  // ==========================================================================
  // Field layouts and reset values
  // ==========================================================================
  localparam int         PLE_CAL_FAIL_BIT = 7;
  localparam int         PLE_CAL_DONE_BIT = 6;
  localparam int         PLE_BAND_W       = 6;
  localparam int         PLE_LOCK_BIT     = 0;
  localparam int         PLE_RAIL_LO_BIT  = 1;
  localparam int         PLE_RAIL_HI_BIT  = 2;
  localparam int         PLE_EVT_W        = 3;
  localparam int         PLE_CNT_W        = 4;
  localparam logic [3:0] PLE_CNT_MAX      = 4'hf;
  localparam logic [3:0] PLE_CNT_RST      = 4'h0;
  localparam logic [7:0] PLE_REG_RST      = 8'h00;
  localparam logic [2:0] PLE_EVT_RST      = 3'h0;

  // ==========================================================================
  // Lock debounce intervals, in system clock cycles
  // ==========================================================================
  localparam logic [1:0]  PLE_DB_SEL_NONE  = 2'h0;
  localparam logic [1:0]  PLE_DB_SEL_SHORT = 2'h1;
  localparam logic [1:0]  PLE_DB_SEL_MID   = 2'h2;
  localparam logic [15:0] PLE_DB_SHORT_CYC = 16'd570;
  localparam logic [15:0] PLE_DB_MID_CYC   = 16'd5700;
  localparam logic [15:0] PLE_DB_LONG_CYC  = 16'd57000;
  localparam logic [15:0] PLE_DB_CNT_ONE   = 16'h0001;
  localparam logic [15:0] PLE_DB_CNT_ZERO  = 16'h0000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic                  cal_done;
    logic                  cal_fail;
    logic [PLE_BAND_W-1:0] band;
    logic                  lock;
    logic                  rail_hi;
    logic                  rail_lo;
  } ple_analog_t;

  typedef struct packed {
    logic       lock_det_disable;
    logic       one_shot_lock_mode;
    logic [1:0] lock_timer_sel;
  } ple_cfg_t;

  typedef struct packed {
    logic       wr;
    logic [1:0] idx;
    logic [7:0] wdata;
  } ple_reg_req_t;

  typedef enum logic [1:0] {
    PLE_DB_UNLOCKED = 2'b00,
    PLE_DB_QUALIFY  = 2'b01,
    PLE_DB_LOCKED   = 2'b10
  } ple_db_state_t;

endpackage : ple_pkg

// ===== hw/ple_lock_debounce.sv
// Lock debouncer: qualifies the raw lock over a selectable interval.
// Assumes raw_lock is already synchronised to core_clk.
`timescale 1ns/100ps
`default_nettype none
module ple_lock_debounce
  import ple_pkg::*;
#(
  parameter logic [15:0] MID_CYC  = PLE_DB_MID_CYC,
  parameter logic [15:0] LONG_CYC = PLE_DB_LONG_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       raw_lock,
  input  wire logic [1:0] timer_sel,
  output logic            lock_out
);

  typedef struct packed {
    ple_db_state_t st;
    logic [15:0]   cnt;
  } ple_db_regs_t;

  ple_db_regs_t regs_ff;
  ple_db_regs_t nxt_regs;
  logic [15:0]  target;

  // ==========================================================================
  // Interval select and qualification
  // ==========================================================================
  always_comb begin
    case (timer_sel)
      // Zero interval also ends a qualification begun under another setting
      PLE_DB_SEL_NONE:  target = PLE_DB_CNT_ZERO;
      PLE_DB_SEL_SHORT: target = PLE_DB_SHORT_CYC;
      PLE_DB_SEL_MID:   target = MID_CYC;
      default:          target = LONG_CYC;
    endcase
  end

  always_comb begin
    nxt_regs = regs_ff;
    case (regs_ff.st)
      PLE_DB_UNLOCKED: begin
        if (raw_lock && timer_sel == PLE_DB_SEL_NONE) begin
          nxt_regs.st = PLE_DB_LOCKED;
        end else if (raw_lock) begin
          nxt_regs.st  = PLE_DB_QUALIFY;
          nxt_regs.cnt = PLE_DB_CNT_ONE;
        end
      end
      PLE_DB_QUALIFY: begin
        // Any dropout restarts qualification; loss is reported at once, and so is lock under the zero interval
        if (!raw_lock) begin
          nxt_regs.st  = PLE_DB_UNLOCKED;
          nxt_regs.cnt = PLE_DB_CNT_ZERO;
        end else if (regs_ff.cnt >= target) begin
          nxt_regs.st = PLE_DB_LOCKED;
        end else begin
          nxt_regs.cnt = regs_ff.cnt + PLE_DB_CNT_ONE;
        end
      end
      PLE_DB_LOCKED: begin
        if (!raw_lock) begin
          nxt_regs.st  = PLE_DB_UNLOCKED;
          nxt_regs.cnt = PLE_DB_CNT_ZERO;
        end
      end
      default: begin
        nxt_regs.st  = PLE_DB_UNLOCKED;
        nxt_regs.cnt = PLE_DB_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regs_ff.st  <= PLE_DB_UNLOCKED;
      regs_ff.cnt <= PLE_DB_CNT_ZERO;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign lock_out = (regs_ff.st == PLE_DB_LOCKED);

endmodule : ple_lock_debounce
`default_nettype wire

// ===== bench/ple_status_bank_properties.sv
// Checker for the PLL status and event bank, bound to its top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module ple_status_bank_properties
  import ple_pkg::*;
#(
  parameter logic [15:0] DB_MID_CYC  = PLE_DB_MID_CYC,
  parameter logic [15:0] DB_LONG_CYC = PLE_DB_LONG_CYC
) (
  input wire logic         core_clk,
  input wire logic         rst,
  input wire ple_analog_t  analog_in,
  input wire ple_cfg_t     cfg,
  input wire ple_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire logic         lock_ind
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_cal_fields: assert property (
    (reg_req.idx == PLE_IDX_CAL_STS && $stable(analog_in))[*5] |=>
    reg_rdata == {$past(analog_in.cal_fail), $past(analog_in.cal_done), $past(analog_in.band)})
    else $error("cal status mismatch");
  a_live_rails: assert property (
    (reg_req.idx == PLE_IDX_LIVE_STS && $stable(analog_in))[*5] |=>
    reg_rdata[7:1] == {5'h00, $past(analog_in.rail_hi), $past(analog_in.rail_lo)})
    else $error("live status mismatch");
  a_lock_bypass: assert property (cfg.lock_det_disable[*3] |-> lock_ind)
    else $error("bypass lock low");
  a_lock_rise: assert property (
    (analog_in.lock && cfg.lock_timer_sel == PLE_DB_SEL_NONE)[*5] |-> lock_ind)
    else $error("lock not seen");
  a_lock_drop: assert property (
    (!analog_in.lock && !cfg.lock_det_disable && !cfg.one_shot_lock_mode)[*5] |-> !lock_ind)
    else $error("lock held while unlocked");
  a_one_shot: assert property (
    (cfg.one_shot_lock_mode && !cfg.lock_det_disable && lock_ind)[*3] |=> lock_ind)
    else $error("one-shot lock dropped");
  a_lol_event: assert property (
    reg_req.idx == PLE_IDX_EVENTS && $fell(lock_ind) |=> reg_rdata[0])
    else $error("loss event missing");
  a_evt_hold: assert property (
    (reg_req.idx == PLE_IDX_EVENTS && !reg_req.wr)[*2] |=>
    ($past(reg_rdata[2:0]) & ~reg_rdata[2:0]) == 3'h0 && reg_rdata[7:3] == 5'h00)
    else $error("event dropped without write");
  a_rail_hi_evt: assert property ((analog_in.rail_hi && reg_req.idx == PLE_IDX_EVENTS)[*4] |=> reg_rdata[2])
    else $error("rail high event missing");
  a_rail_lo_evt: assert property ((analog_in.rail_lo && reg_req.idx == PLE_IDX_EVENTS)[*4] |=> reg_rdata[1])
    else $error("rail low event missing");
  a_lol_count: assert property (
    (reg_req.idx == PLE_IDX_LOL_CNT && !reg_req.wr) ##1
    (reg_req.idx == PLE_IDX_LOL_CNT && $fell(lock_ind)) |=>
    reg_rdata[3:0] == (($past(reg_rdata[3:0]) == PLE_CNT_MAX) ? PLE_CNT_MAX : $past(reg_rdata[3:0]) + 4'h1))
    else $error("loss counter step wrong");

  c_loss: cover property ($fell(lock_ind));
  c_preset: cover property (reg_req.wr && reg_req.idx == PLE_IDX_LOL_CNT);
  c_one_shot: cover property (cfg.one_shot_lock_mode && lock_ind && !analog_in.lock);
endmodule : ple_status_bank_properties

bind ple_status_bank ple_status_bank_properties #(.DB_MID_CYC(DB_MID_CYC), .DB_LONG_CYC(DB_LONG_CYC)) u_props (
  .core_clk(core_clk), .rst(rst), .analog_in(analog_in), .cfg(cfg),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .lock_ind(lock_ind));
`default_nettype wire

// ===== bench/ple_status_bank_tb.sv
// Self-checking bench for the PLL status and event bank.
// Assumes debounce counts shortened to 20 and 40 cycles; 570 stays fixed.
`timescale 1ns/100ps
`default_nettype none
module ple_status_bank_tb
  import ple_pkg::*;
;
  logic         core_clk;
  logic         rst;
  ple_analog_t  an;
  ple_cfg_t     cfg;
  ple_reg_req_t rq;
  logic [7:0]   rdata;
  logic         lock_ind;
  int           failures;
  int           n_compared;

  ple_status_bank #(.DB_MID_CYC(16'd20), .DB_LONG_CYC(16'd40)) u_dut (
    .core_clk(core_clk), .rst(rst), .analog_in(an), .cfg(cfg),
    .reg_req(rq), .reg_rdata(rdata), .lock_ind(lock_ind));

  // ==========================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [1:0] i, input logic [7:0] e, input string nm);
    rq.idx = i;
    tick(2);
    chk(nm, e, rdata);
  endtask : rd
  task automatic wr(input logic [1:0] i, input logic [7:0] d);
    rq.idx = i; rq.wdata = d; rq.wr = 1'b1;
    tick(1);
    rq.wr = 1'b0;
  endtask : wr
  task automatic wrap_up;
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rd(2'(i), 8'h00, "reset");
    wr(PLE_IDX_EVENTS, 8'hff); rd(PLE_IDX_EVENTS, 8'h00, "evt_rsv");
    wr(PLE_IDX_LIVE_STS, 8'hff); rd(PLE_IDX_LIVE_STS, 8'h00, "live_ro");
  endtask : t_reset
  task automatic t_cal;
    an.band = 6'h15; tick(2); rd(PLE_IDX_CAL_STS, 8'h15, "cal_busy");
    an.cal_done = 1; an.cal_fail = 1; an.band = 6'h2a; tick(4);
    rd(PLE_IDX_CAL_STS, 8'hea, "cal_fail");
    an.cal_fail = 0; tick(4); rd(PLE_IDX_CAL_STS, 8'h6a, "cal_ok");
    tick(4);
  endtask : t_cal
  task automatic t_rail;
    rq.idx = PLE_IDX_EVENTS; an.rail_hi = 1; tick(6); rd(PLE_IDX_LIVE_STS, 8'h04, "rail_hi");
    rq.idx = PLE_IDX_EVENTS; an.rail_hi = 0; an.rail_lo = 1; tick(6);
    rd(PLE_IDX_LIVE_STS, 8'h02, "rail_lo");
    tick(4); an.rail_lo = 0; tick(4); rd(PLE_IDX_EVENTS, 8'h06, "rail_evt");
    wr(PLE_IDX_EVENTS, 8'hfa); rd(PLE_IDX_EVENTS, 8'h04, "evt_w1c");
    wr(PLE_IDX_EVENTS, 8'h04); rd(PLE_IDX_EVENTS, 8'h00, "evt_clr");
  endtask : t_rail
  task automatic t_lock;
    an.lock = 1; tick(6); chk("lock_up", 8'h01, 8'(lock_ind));
    rd(PLE_IDX_LIVE_STS, 8'h01, "lock_live");
    rq.idx = PLE_IDX_EVENTS; an.lock = 0; tick(6); chk("lock_dn", 8'h00, 8'(lock_ind));
    rd(PLE_IDX_EVENTS, 8'h01, "lol_evt");
    wr(PLE_IDX_EVENTS, 8'h01); tick(6); rd(PLE_IDX_EVENTS, 8'h00, "lol_once");
    rd(PLE_IDX_LOL_CNT, 8'h01, "lol_cnt");
  endtask : t_lock
  task automatic t_cnt;
    wr(PLE_IDX_LOL_CNT, 8'hfe); rd(PLE_IDX_LOL_CNT, 8'h0e, "cnt_preset");
    repeat (2) begin
      an.lock = 1; tick(6); an.lock = 0; tick(6);
    end
    rd(PLE_IDX_LOL_CNT, 8'h0f, "cnt_sat");
    wr(PLE_IDX_LOL_CNT, 8'h00); rd(PLE_IDX_LOL_CNT, 8'h00, "cnt_clr");
  endtask : t_cnt
  task automatic t_modes;
    cfg.lock_det_disable = 1; tick(3); chk("bypass", 8'h01, 8'(lock_ind));
    cfg.lock_det_disable = 0; tick(6);
    cfg.one_shot_lock_mode = 1; an.lock = 1; tick(6); an.lock = 0; tick(8);
    chk("one_shot", 8'h01, 8'(lock_ind));
    cfg.one_shot_lock_mode = 0; tick(6); chk("one_shot_off", 8'h00, 8'(lock_ind));
  endtask : t_modes
  task automatic t_deb;
    int tg[3] = '{570, 20, 40};
    for (int s = 1; s < 4; s++) begin
      cfg.lock_timer_sel = 2'(s); an.lock = 1; tick(tg[s-1] - 8);
      chk("deb_early", 8'h00, 8'(lock_ind));
      tick(16); chk("deb_late", 8'h01, 8'(lock_ind));
      an.lock = 0; tick(6);
    end
    cfg.lock_timer_sel = PLE_DB_SEL_NONE;
  endtask : t_deb

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
  initial begin
    failures = 0; n_compared = 0; rst = 1'b1; an = '0; cfg = '0; rq = '0;
    tick(8);
    rst = 1'b0;
    t_reset; t_cal; t_rail; t_lock; t_cnt; t_modes; t_deb;
    wrap_up;
  end
endmodule : ple_status_bank_tb
`default_nettype wire
